// ===== plrd_strap_decode.v
// Ratio strap capture and clock plan decode
`timescale 1ns/1ps
`include "plrd_consts.vh"
module plrd_strap_decode (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_hard_reset_n,
    input wire [5:0] i_ratio_strap,
    input wire [1:0] i_dynamic_frequency_switching,
    input wire i_bypass_clock_qualifier,
    output reg [1:0] o_mode,
    output reg [6:0] o_core_mult_half,
    output reg [1:0] o_vco_mult,
    output reg o_pll_enable,
    output reg o_core_clock_en,
    output reg o_bus_clock_en,
    output reg o_low_ratio,
    output reg o_strap_reserved
);
    wire [5:0] strap_s;
    wire hard_reset_n_s;
    wire [1:0] freq_switch_s;
    wire qual_s;
    reg [5:0] cap_reg;
    reg [5:0] cap_next;
    reg [6:0] base_half;
    reg [1:0] mode_dec;
    reg [6:0] eff_half;
    reg qual_d_reg;
    reg [1:0] live_reg;
    reg [1:0] live_next;
    reg [1:0] mode_next;
    reg [6:0] mult_next;
    reg [1:0] vco_next;
    reg pll_next;
    reg core_en_next;
    reg bus_en_next;
    reg low_next;
    reg rsvd_next;
    wire qual_rise;
    wire capture_open;

    // Pins pass two flip-flops before any logic reads them
    plrd_sync2 #(.WIDTH(10)) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_ratio_strap, i_hard_reset_n, i_dynamic_frequency_switching, i_bypass_clock_qualifier}),
        .o_sync({strap_s, hard_reset_n_s, freq_switch_s, qual_s})
    );

    // Synchroniser warm-up: its reset value is no real pin level
    always @* begin
        live_next = {live_reg[0], 1'b1};
    end

    // Window opens while synchronised hard reset is asserted, once synchronised pins are real
    assign capture_open = live_reg[1] && !hard_reset_n_s;

    always @* begin
        cap_next = cap_reg;
        if (capture_open) begin
            cap_next = strap_s;
        end
    end

    // Strap table decode
    always @* begin
        mode_dec = `PLRD_MODE_PLL;
        base_half = `PLRD_HALF_ZERO;
        case (cap_reg)
            `PLRD_CFG_11X: base_half = `PLRD_HALF_11X;
            `PLRD_CFG_11P5X: base_half = `PLRD_HALF_11P5X;
            `PLRD_CFG_12X: base_half = `PLRD_HALF_12X;
            `PLRD_CFG_12P5X: base_half = `PLRD_HALF_12P5X;
            `PLRD_CFG_13X: base_half = `PLRD_HALF_13X;
            `PLRD_CFG_13P5X: base_half = `PLRD_HALF_13P5X;
            `PLRD_CFG_14X: base_half = `PLRD_HALF_14X;
            `PLRD_CFG_15X: base_half = `PLRD_HALF_15X;
            `PLRD_CFG_16X: base_half = `PLRD_HALF_16X;
            `PLRD_CFG_17X: base_half = `PLRD_HALF_17X;
            `PLRD_CFG_18X: base_half = `PLRD_HALF_18X;
            `PLRD_CFG_20X: base_half = `PLRD_HALF_20X;
            `PLRD_CFG_21X: base_half = `PLRD_HALF_21X;
            `PLRD_CFG_24X: base_half = `PLRD_HALF_24X;
            `PLRD_CFG_28X: base_half = `PLRD_HALF_28X;
            `PLRD_CFG_BYPASS: begin
                mode_dec = `PLRD_MODE_BYPASS;
                base_half = `PLRD_HALF_1X;
            end
            `PLRD_CFG_OFF: mode_dec = `PLRD_MODE_OFF;
            default: mode_dec = `PLRD_MODE_RSVD;
        endcase
    end

    always @* begin
        eff_half = base_half;
        if (mode_dec == `PLRD_MODE_PLL) begin
            case (freq_switch_s)
                `PLRD_SWITCH_DIV2: eff_half = {1'b0, base_half[6:1]};
                `PLRD_SWITCH_DIV4: eff_half = {2'b00, base_half[6:2]};
                default: eff_half = base_half;
            endcase
        end
    end

    // One-cycle pulse on each rising edge of the synchronised qualifier
    assign qual_rise = qual_s && !qual_d_reg;

    // Next values of the clock plan outputs
    always @* begin
        mode_next = mode_dec;
        mult_next = eff_half;
        vco_next = `PLRD_VCO_NONE;
        pll_next = 1'b0;
        core_en_next = 1'b0;
        bus_en_next = 1'b0;
        low_next = 1'b0;
        rsvd_next = 1'b0;
        case (mode_dec)
            `PLRD_MODE_PLL: begin
                vco_next = `PLRD_VCO_MULT;
                pll_next = 1'b1;
                core_en_next = 1'b1;
                // Bus clock runs every cycle under the loop
                bus_en_next = 1'b1;
                // Snoop margin flag for bus logic below five times
                low_next = (eff_half < `PLRD_HALF_LOW);
            end
            `PLRD_MODE_BYPASS: begin
                core_en_next = 1'b1;
                bus_en_next = qual_rise;
            end
            `PLRD_MODE_RSVD: begin
                rsvd_next = 1'b1;
            end
            default: begin
                core_en_next = 1'b0;
            end
        endcase
    end

    // Warm-up shift register and captured strap word
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            live_reg <= `PLRD_LIVE_RESET;
            // Off until a hard reset has really been seen
            cap_reg <= `PLRD_CFG_OFF;
        end else begin
            live_reg <= live_next;
            cap_reg <= cap_next;
        end
    end

    // Qualifier history for the edge detector
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            qual_d_reg <= 1'b0;
        end else begin
            qual_d_reg <= qual_s;
        end
    end

    // Mode and multiplier outputs
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_mode <= `PLRD_MODE_OFF;
            o_core_mult_half <= `PLRD_HALF_ZERO;
        end else begin
            o_mode <= mode_next;
            o_core_mult_half <= mult_next;
        end
    end

    // Oscillator ratio and loop enable outputs
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_vco_mult <= `PLRD_VCO_NONE;
            o_pll_enable <= 1'b0;
        end else begin
            o_vco_mult <= vco_next;
            o_pll_enable <= pll_next;
        end
    end

    // Core and bus clock enables
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_core_clock_en <= 1'b0;
            o_bus_clock_en <= 1'b0;
        end else begin
            o_core_clock_en <= core_en_next;
            o_bus_clock_en <= bus_en_next;
        end
    end

    // Status flags for the system side
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_low_ratio <= 1'b0;
            o_strap_reserved <= 1'b0;
        end else begin
            o_low_ratio <= low_next;
            o_strap_reserved <= rsvd_next;
        end
    end
endmodule // plrd_strap_decode

// ===== plrd_consts.vh
// Constants for the strap decoder of the core clock plan
`ifndef PLRD_CONSTS_VH
`define PLRD_CONSTS_VH
`define PLRD_CFG_11X 6'h26
`define PLRD_CFG_11P5X 6'h00
`define PLRD_CFG_12X 6'h2e
`define PLRD_CFG_12P5X 6'h3e
`define PLRD_CFG_13X 6'h16
`define PLRD_CFG_13P5X 6'h38
`define PLRD_CFG_14X 6'h32
`define PLRD_CFG_15X 6'h06
`define PLRD_CFG_16X 6'h36
`define PLRD_CFG_17X 6'h02
`define PLRD_CFG_18X 6'h0a
`define PLRD_CFG_20X 6'h0e
`define PLRD_CFG_21X 6'h12
`define PLRD_CFG_24X 6'h1a
`define PLRD_CFG_28X 6'h3a
`define PLRD_CFG_BYPASS 6'h0c
`define PLRD_CFG_OFF 6'h3c
// Multiplier held in half steps: 22 means 11x
`define PLRD_HALF_11X 7'h16
`define PLRD_HALF_11P5X 7'h17
`define PLRD_HALF_12X 7'h18
`define PLRD_HALF_12P5X 7'h19
`define PLRD_HALF_13X 7'h1a
`define PLRD_HALF_13P5X 7'h1b
`define PLRD_HALF_14X 7'h1c
`define PLRD_HALF_15X 7'h1e
`define PLRD_HALF_16X 7'h20
`define PLRD_HALF_17X 7'h22
`define PLRD_HALF_18X 7'h24
`define PLRD_HALF_20X 7'h28
`define PLRD_HALF_21X 7'h2a
`define PLRD_HALF_24X 7'h30
`define PLRD_HALF_28X 7'h38
`define PLRD_HALF_1X 7'h02
`define PLRD_HALF_ZERO 7'h00
`define PLRD_HALF_LOW 7'h0a
// Oscillator to core ratio
`define PLRD_VCO_MULT 2'h1
`define PLRD_VCO_NONE 2'h0
// Synchroniser warm-up shift register after reset
`define PLRD_LIVE_RESET 2'h0
// Clock plan modes
`define PLRD_MODE_PLL 2'h0
`define PLRD_MODE_BYPASS 2'h1
`define PLRD_MODE_OFF 2'h2
`define PLRD_MODE_RSVD 2'h3
// Dynamic frequency switching divide selects
`define PLRD_SWITCH_NONE 2'h0
`define PLRD_SWITCH_DIV2 2'h1
`define PLRD_SWITCH_DIV4 2'h2
`endif

// ===== plrd_sync2.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module plrd_sync2 #(
    parameter WIDTH = 1
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_reg <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule // plrd_sync2

// ===== plrd_board_model.sv
// Board clock source model for the bypass qualifier
`timescale 1ns/1ps
module plrd_board_model (
    input wire i_clk,
    input wire i_reset_n,
    output reg o_qual
);
    always @(posedge i_clk) begin
        o_qual <= i_reset_n ? ~o_qual : 1'b0;
    end
endmodule // plrd_board_model

// ===== plrd_check_monitor.sv
// Port checker for the strap decoder
`timescale 1ns/1ps
module plrd_monitor (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_hard_reset_n,
    input wire [5:0] i_ratio_strap,
    input wire [1:0] o_mode,
    input wire [6:0] o_core_mult_half,
    input wire [1:0] o_vco_mult,
    input wire o_pll_enable,
    input wire o_core_clock_en,
    input wire o_bus_clock_en,
    input wire o_low_ratio
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Strap held steady under hard reset
    sequence s_cap;
        (!i_hard_reset_n && $stable(i_ratio_strap))[*6];
    endsequence
    property p_pll; o_mode == 2'h0 |-> o_pll_enable && o_core_clock_en && o_vco_mult == 2'h1; endproperty
    a_pll: assert property (p_pll) else $error("pll outputs");
    property p_off; o_mode == 2'h2 |-> !o_core_clock_en && !o_bus_clock_en && o_core_mult_half == 7'h00; endproperty
    a_off: assert property (p_off) else $error("off outputs");
    property p_byp; o_mode == 2'h1 |-> o_core_clock_en && !o_pll_enable && o_core_mult_half == 7'h02; endproperty
    a_byp: assert property (p_byp) else $error("bypass outputs");
    property p_bus; o_mode == 2'h1 && o_bus_clock_en |=> !o_bus_clock_en || o_mode != 2'h1; endproperty
    a_bus: assert property (p_bus) else $error("bus rate");
    property p_vco; o_mode != 2'h0 |-> o_vco_mult == 2'h0 && !o_low_ratio; endproperty
    a_vco: assert property (p_vco) else $error("vco ratio");
    property p_hold; i_hard_reset_n[*6] |=> $stable(o_mode); endproperty
    a_hold: assert property (p_hold) else $error("mode moved");
    property p_dbyp; s_cap |-> (i_ratio_strap == 6'h0c) == (o_mode == 2'h1); endproperty
    a_dbyp: assert property (p_dbyp) else $error("bypass decode");
    property p_doff; s_cap |-> (i_ratio_strap == 6'h3c) == (o_mode == 2'h2); endproperty
    a_doff: assert property (p_doff) else $error("off decode");
endmodule // plrd_monitor
bind plrd_strap_decode plrd_monitor u_mon (.i_clk, .i_reset_n, .i_hard_reset_n, .i_ratio_strap, .o_mode,
    .o_core_mult_half, .o_vco_mult, .o_pll_enable, .o_core_clock_en, .o_bus_clock_en, .o_low_ratio);

// ===== pll_ratio_strap_decode_tb_top.sv
// Self-checking bench for the strap decoder
`timescale 1ns/1ps
module pll_ratio_strap_decode_tb_top;
    reg i_clk = 1'b0;
    reg i_reset_n = 1'b0;
    reg i_hard_reset_n = 1'b0;
    reg [5:0] i_ratio_strap = 6'h00;
    reg [1:0] i_dynamic_frequency_switching = 2'h0;
    wire i_bypass_clock_qualifier, o_pll_enable, o_core_clock_en, o_bus_clock_en, o_low_ratio, o_strap_reserved;
    wire [1:0] o_mode;
    wire [1:0] o_vco_mult;
    wire [6:0] o_core_mult_half;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int k, d, n, eh, em;
    reg [5:0] codes [0:17] = '{6'h26, 6'h00, 6'h2e, 6'h3e, 6'h16, 6'h38, 6'h32, 6'h06, 6'h36, 6'h02, 6'h0a,
        6'h0e, 6'h12, 6'h1a, 6'h3a, 6'h0c, 6'h3c, 6'h01};
    reg [6:0] halves [0:17] = '{7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1e, 7'h20, 7'h22, 7'h24,
        7'h28, 7'h2a, 7'h30, 7'h38, 7'h02, 7'h00, 7'h00};
    plrd_board_model u_board (.i_clk, .i_reset_n, .o_qual(i_bypass_clock_qualifier));
    plrd_strap_decode u_dut (.i_clk, .i_reset_n, .i_hard_reset_n, .i_ratio_strap, .i_dynamic_frequency_switching,
        .i_bypass_clock_qualifier, .o_mode, .o_core_mult_half, .o_vco_mult, .o_pll_enable, .o_core_clock_en,
        .o_bus_clock_en, .o_low_ratio, .o_strap_reserved);
    always #50 i_clk = ~i_clk;
    // Hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    task check(input [6:0] seen, input [6:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Capture a strap under hard reset, then disturb the pins
    task cap(input [5:0] s);
        i_hard_reset_n = 1'b0;
        i_ratio_strap = s;
        repeat (8) @(negedge i_clk);
        // Late pin noise must be ignored once hard reset is gone
        i_hard_reset_n = 1'b1;
        i_ratio_strap = 6'($urandom);
        repeat (6) @(negedge i_clk);
    endtask
    initial begin
        n = $urandom(32'hb54bc714);
        repeat (2) @(negedge i_clk);
        i_reset_n = 1'b1;
        for (k = 0; k < 18; k++) begin
            for (d = 0; d < (k < 15 ? 4 : 1); d++) begin
                i_dynamic_frequency_switching = 2'(d);
                cap(codes[k]);
                em = k < 15 ? 0 : k - 14;
                eh = (d < 3) ? halves[k] >> d : halves[k];
                check(7'(o_mode), 7'(em));
                check(o_core_mult_half, 7'(eh));
                check(7'(o_low_ratio), 7'(em == 0 && eh < 10));
                check(7'(o_strap_reserved), 7'(k == 17));
                check(7'(o_vco_mult), 7'(em == 0));
                check(7'(o_pll_enable), 7'(em == 0));
                check(7'(o_core_clock_en), 7'(em < 2));
                n = 0;
                repeat (8) begin
                    @(negedge i_clk);
                    n += o_bus_clock_en;
                end
                check(7'(n), k == 15 ? 7'h04 : (k < 15 ? 7'h08 : 7'h00));
            end
        end
        // Mid-run reset with hard reset idle falls back to the off plan
        i_reset_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_reset_n = 1'b1;
        repeat (6) @(negedge i_clk);
        check(7'(o_mode), 7'h02);
        check(o_core_mult_half, 7'h00);
        summarize();
    end
endmodule // pll_ratio_strap_decode_tb_top
